// ### core/cpd_pkg.sv
package cpd_pkg;

  // ----------------------------------------------------------------------
  // Record layout
  // ----------------------------------------------------------------------
  localparam logic [15:0] CPD_PIN_BASE = 16'h0058;
  localparam logic [15:0] CPD_PIN_SPAN = 16'h0094;
  localparam int CPD_PIN_WORDS = 74;
  localparam logic [15:0] CPD_LIM_3V3_OFF = 16'h00EC;
  localparam logic [15:0] CPD_LIM_5V_OFF = 16'h00EE;
  localparam logic [15:0] CPD_LIM_SYS_OFF = 16'h00F0;
  localparam logic [15:0] CPD_SUPPLY_OFF = 16'h00F2;
  localparam logic [15:0] CPD_FREE_OFF = 16'h00F4;
  localparam logic [15:0] CPD_FREE_SPAN = 16'h7F1F;
  localparam logic [15:0] CPD_LAST_OFF = 16'h00F3;
  localparam int CPD_FIRST_ANALOG = 67;

  // ----------------------------------------------------------------------
  // Pin word fields
  // ----------------------------------------------------------------------
  localparam int CPD_BIT_USED = 15;
  localparam int CPD_BIT_SLEW = 6;
  localparam int CPD_BIT_RXEN = 5;
  localparam int CPD_BIT_PULL_DIR = 4;
  localparam int CPD_BIT_PULL_EN_N = 3;
  localparam int CPD_MUX_MSB = 2;

  // ----------------------------------------------------------------------
  // Avalon register map (word offsets, byte address = 4 x index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] CPD_REG_CTRL = 8'h00;
  localparam logic [7:0] CPD_REG_STATUS = 8'h01;
  localparam logic [7:0] CPD_REG_LIM_3V3 = 8'h02;
  localparam logic [7:0] CPD_REG_LIM_5V = 8'h03;
  localparam logic [7:0] CPD_REG_LIM_SYS = 8'h04;
  localparam logic [7:0] CPD_REG_SUPPLY = 8'h05;
  localparam logic [7:0] CPD_REG_PIN_BASE = 8'h40;
  localparam logic [31:0] CPD_RESET_VALUE = 32'h0000_0000;
  localparam logic [31:0] CPD_UNMAPPED = 32'hDEAD_0000;

  typedef enum logic [1:0] {
    CPD_IDLE = 2'b00,
    CPD_FETCH = 2'b01,
    CPD_WAIT = 2'b10,
    CPD_DONE = 2'b11
  } cpd_state_type;

endpackage

// ### core/cpd_byte_if.sv
`timescale 1ns/1ps
interface cpd_byte_if;
  logic valid;
  logic [15:0] offset;
  logic [7:0] data;

  modport src (output valid, output offset, output data);
  modport dst (input valid, input offset, input data);
endinterface

// ### core/cpd_word_pack.sv
`timescale 1ns/1ps
module cpd_word_pack
  import cpd_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  cpd_byte_if.dst byte_in,
  output logic o_word_valid,
  output logic [15:0] o_word_offset,
  output logic [15:0] o_word
);

  // ----------------------------------------------------------------------
  // Big-endian pairing
  // ----------------------------------------------------------------------
  logic [7:0] high_q;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      high_q <= 8'h00;
    end else if (byte_in.valid && !byte_in.offset[0]) begin
      high_q <= byte_in.data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_word_valid <= 1'b0;
      o_word <= 16'h0000;
      o_word_offset <= 16'h0000;
    end else begin
      o_word_valid <= byte_in.valid && byte_in.offset[0];
      if (byte_in.valid && byte_in.offset[0]) begin
        o_word <= {high_q, byte_in.data};
        o_word_offset <= {byte_in.offset[15:1], 1'b0};
      end
    end
  end

endmodule

// ### core/cpd_pin_decode.sv
`timescale 1ns/1ps
module cpd_pin_decode
  import cpd_pkg::*;
#(
  parameter int PINS = CPD_PIN_WORDS
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_word_valid,
  input wire logic [15:0] i_word_offset,
  input wire logic [15:0] i_word,
  input wire logic [6:0] i_sel,
  output logic [15:0] o_word,
  output logic o_used,
  output logic o_slew,
  output logic o_rx_enable,
  output logic o_pull_direction_select,
  output logic o_pull_enable_n,
  output logic [2:0] o_mux_mode
);

  // ----------------------------------------------------------------------
  // Pin word store, one entry per connector pin
  // ----------------------------------------------------------------------
  logic [15:0] words_q [PINS];
  logic [15:0] rel;
  logic in_pins;
  logic [6:0] idx;
  logic [15:0] sel_word;
  logic analog;

  assign rel = i_word_offset - CPD_PIN_BASE;
  assign in_pins = (i_word_offset >= CPD_PIN_BASE) &&
                   (rel < CPD_PIN_SPAN);
  assign idx = rel[7:1];

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      for (int i = 0; i < PINS; i++) begin
        words_q[i] <= 16'h0000;
      end
    end else if (i_word_valid && in_pins) begin
      words_q[idx] <= i_word;
    end
  end

  assign sel_word = (int'(i_sel) < PINS) ? words_q[i_sel] : 16'h0000;
  assign analog = int'(i_sel) >= CPD_FIRST_ANALOG;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_word <= 16'h0000;
      o_used <= 1'b0;
      o_slew <= 1'b0;
      o_rx_enable <= 1'b0;
      o_pull_direction_select <= 1'b0;
      o_pull_enable_n <= 1'b1;
      o_mux_mode <= 3'h0;
    end else begin
      o_word <= sel_word;
      o_used <= sel_word[CPD_BIT_USED];
      // Analog pins carry no pad settings; park them at safe values
      o_slew <= !analog && sel_word[CPD_BIT_SLEW];
      o_rx_enable <= !analog && sel_word[CPD_BIT_RXEN];
      o_pull_direction_select <=
        !analog && sel_word[CPD_BIT_PULL_DIR];
      o_pull_enable_n <=
        analog || sel_word[CPD_BIT_PULL_EN_N];
      o_mux_mode <= analog ? 3'h0 : sel_word[CPD_MUX_MSB:0];
    end
  end

endmodule

// ### core/cpd_top.sv
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module cpd_top
  import cpd_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_fetch_req,
  output logic [15:0] o_fetch_addr,
  input wire logic i_fetch_ack,
  input wire logic [7:0] i_fetch_data,
  output logic o_done,
  output logic [15:0] o_pad_word,
  output logic o_pad_used,
  output logic o_pad_slew,
  output logic o_pad_rx_enable,
  output logic o_pad_pull_direction_select,
  output logic o_pad_pull_enable_n,
  output logic [2:0] o_pad_mux_mode,
  output logic [15:0] o_rail_3v3_limit,
  output logic [15:0] o_rail_5v_limit,
  output logic [15:0] o_system_5v_limit,
  output logic [15:0] o_supply_current,
  output logic o_supplies_5v
);

  // ----------------------------------------------------------------------
  // Loader sequencer
  // ----------------------------------------------------------------------
  cpd_state_type state_q;
  logic [15:0] addr_q;
  logic start;
  logic [6:0] pin_sel_q;
  cpd_byte_if byte_bus ();
  logic word_valid;
  logic [15:0] word_offset;
  logic [15:0] word;
  logic busy;

  // Busy spans the whole load, not only a request in flight
  assign busy = state_q == CPD_FETCH || state_q == CPD_WAIT;

  // One request in flight at a time; the reader may answer late
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      state_q <= CPD_IDLE;
    end else begin
      unique case (state_q)
        CPD_IDLE: begin
          if (start) begin
            state_q <= CPD_FETCH;
          end
        end
        CPD_FETCH: begin
          state_q <= CPD_WAIT;
        end
        CPD_WAIT: begin
          if (i_fetch_ack && addr_q == CPD_LAST_OFF) begin
            state_q <= CPD_DONE;
          end else if (i_fetch_ack) begin
            state_q <= CPD_FETCH;
          end
        end
        CPD_DONE: begin
          if (start) begin
            state_q <= CPD_FETCH;
          end
        end
      endcase
    end
  end

  // Counts record bytes; a restart always begins at the first pin word
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      addr_q <= CPD_PIN_BASE;
    end else if (start && (state_q == CPD_IDLE || state_q == CPD_DONE)) begin
      addr_q <= CPD_PIN_BASE;
    end else if (state_q == CPD_WAIT && i_fetch_ack) begin
      addr_q <= addr_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Fetch port
  // ----------------------------------------------------------------------
  // One byte per request, each with a full two-byte location
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_fetch_req <= 1'b0;
    end else if (state_q == CPD_FETCH) begin
      o_fetch_req <= 1'b1;
    end else if (i_fetch_ack) begin
      o_fetch_req <= 1'b0;
    end
  end

  // Address moves only while no request stands, so the reader sees it steady
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_fetch_addr <= 16'h0000;
    end else if (state_q == CPD_FETCH) begin
      o_fetch_addr <= addr_q;
    end
  end

  // ----------------------------------------------------------------------
  // Completion
  // ----------------------------------------------------------------------
  // Last byte beats a restart in the same cycle so a finished load shows
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_done <= 1'b0;
    end else if (state_q == CPD_WAIT && i_fetch_ack &&
                 addr_q == CPD_LAST_OFF) begin
      o_done <= 1'b1;
    end else if (start) begin
      o_done <= 1'b0;
    end
  end

  // Bytes reach the pairing stage in the cycle the reader answers
  assign byte_bus.valid = (state_q == CPD_WAIT) && i_fetch_ack;
  assign byte_bus.offset = addr_q;
  assign byte_bus.data = i_fetch_data;

  // Pairs bytes into big-endian words before anything decodes them
  cpd_word_pack u_pack (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .byte_in(byte_bus),
    .o_word_valid(word_valid),
    .o_word_offset(word_offset),
    .o_word(word)
  );

  cpd_pin_decode u_pins (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_word_valid(word_valid),
    .i_word_offset(word_offset),
    .i_word(word),
    .i_sel(pin_sel_q),
    .o_word(o_pad_word),
    .o_used(o_pad_used),
    .o_slew(o_pad_slew),
    .o_rx_enable(o_pad_rx_enable),
    .o_pull_direction_select(o_pad_pull_direction_select),
    .o_pull_enable_n(o_pad_pull_enable_n),
    .o_mux_mode(o_pad_mux_mode)
  );

  // ----------------------------------------------------------------------
  // Power fields
  // ----------------------------------------------------------------------
  logic hit_3v3;
  logic hit_5v;
  logic hit_sys;
  logic hit_supply;

  // Pair offsets are even, so each field is caught once, with its low byte
  assign hit_3v3 = word_valid && word_offset == CPD_LIM_3V3_OFF;
  assign hit_5v = word_valid && word_offset == CPD_LIM_5V_OFF;
  assign hit_sys = word_valid && word_offset == CPD_LIM_SYS_OFF;
  assign hit_supply = word_valid && word_offset == CPD_SUPPLY_OFF;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_rail_3v3_limit <= 16'h0000;
    end else if (hit_3v3) begin
      o_rail_3v3_limit <= word;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_rail_5v_limit <= 16'h0000;
    end else if (hit_5v) begin
      o_rail_5v_limit <= word;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_system_5v_limit <= 16'h0000;
    end else if (hit_sys) begin
      o_system_5v_limit <= word;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_supply_current <= 16'h0000;
    end else if (hit_supply) begin
      o_supply_current <= word;
    end
  end

  // Flag kept beside the field so downstream logic need not test it for zero; no register reads it back
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_supplies_5v <= 1'b0;
    end else if (hit_supply) begin
      o_supplies_5v <= word != 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // Avalon slave: one wait cycle, then answer
  // ----------------------------------------------------------------------
  // Every access pays one wait state; in return the answer is registered
  logic wait_done_q;
  logic access;
  logic accept;
  logic [31:0] rdata;

  assign access = (i_avs_read || i_avs_write) && !wait_done_q;
  assign accept = i_avs_write && wait_done_q;
  assign start = accept && i_avs_address == CPD_REG_CTRL &&
                 i_avs_writedata[0];

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      wait_done_q <= 1'b0;
    end else begin
      wait_done_q <= access;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !access;
    end
  end

  // ----------------------------------------------------------------------
  // Pad window
  // ----------------------------------------------------------------------
  // Selects which pin's settings drive the pad outputs
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      pin_sel_q <= 7'h00;
    end else if (accept && i_avs_address == CPD_REG_STATUS) begin
      pin_sel_q <= i_avs_writedata[6:0];
    end
  end

  // ----------------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------------
  always_comb begin
    rdata = CPD_RESET_VALUE;
    unique case (i_avs_address)
      CPD_REG_CTRL: rdata = {25'h0, pin_sel_q};
      CPD_REG_STATUS: rdata = {30'h0, busy, o_done};
      CPD_REG_LIM_3V3: rdata = {16'h0, o_rail_3v3_limit};
      CPD_REG_LIM_5V: rdata = {16'h0, o_rail_5v_limit};
      CPD_REG_LIM_SYS: rdata = {16'h0, o_system_5v_limit};
      CPD_REG_SUPPLY: rdata = {16'h0, o_supply_current};
      CPD_REG_PIN_BASE: rdata = {16'h0, o_pad_word};
      default: rdata = CPD_UNMAPPED;
    endcase
  end

  // Captured at the access edge, so it stands when waitrequest drops
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_avs_readdata <= CPD_RESET_VALUE;
    end else if (access && i_avs_read) begin
      o_avs_readdata <= rdata;
    end
  end

endmodule

// ### verif/cpd_checker_assertions.sv
`timescale 1ns/1ps
module cpd_checker
  import cpd_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic o_fetch_req,
  input wire logic [15:0] o_fetch_addr,
  input wire logic i_fetch_ack,
  input wire logic o_done,
  input wire logic [15:0] o_pad_word,
  input wire logic o_pad_used,
  input wire logic o_pad_slew,
  input wire logic o_pad_rx_enable,
  input wire logic o_pad_pull_direction_select,
  input wire logic o_pad_pull_enable_n,
  input wire logic [2:0] o_pad_mux_mode,
  input wire logic [15:0] o_supply_current,
  input wire logic o_supplies_5v
);
  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  a_fetch_in_range: assert property (
    o_fetch_req |-> o_fetch_addr >= CPD_PIN_BASE &&
    o_fetch_addr <= CPD_LAST_OFF)
    else $error("fetch outside record");
  a_fetch_held: assert property (
    o_fetch_req && !i_fetch_ack |=> o_fetch_req && $stable(o_fetch_addr))
    else $error("fetch request dropped early");
  a_fetch_drop: assert property (i_fetch_ack |=> !o_fetch_req)
    else $error("fetch request held after ack");
  a_fetch_step: assert property (
    i_fetch_ack && o_fetch_addr < CPD_LAST_OFF |-> ##2
    (o_fetch_req && o_fetch_addr == $past(o_fetch_addr, 2) + 16'h0001))
    else $error("fetch order broken");
  a_wait_one: assert property ($rose(i_avs_read) |=> !o_avs_waitrequest)
    else $error("read not answered after one wait state");
  a_wait_short: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  a_read_unmapped: assert property (i_avs_read && !o_avs_waitrequest &&
    i_avs_address inside {[8'h06:8'h3F]} |-> o_avs_readdata == CPD_UNMAPPED)
    else $error("unmapped read value wrong");
  a_supply_flag: assert property (
    o_done |-> o_supplies_5v == (o_supply_current != 16'h0000))
    else $error("supply flag wrong");
  a_pad_used: assert property (o_pad_used == o_pad_word[15])
    else $error("used flag wrong");
  a_pad_fields: assert property (
    ({o_pad_slew, o_pad_rx_enable, o_pad_pull_direction_select,
      o_pad_pull_enable_n, o_pad_mux_mode} == o_pad_word[6:0]) ||
    ({o_pad_slew, o_pad_rx_enable, o_pad_pull_direction_select,
      o_pad_pull_enable_n, o_pad_mux_mode} == 7'h08))
    else $error("pad fields wrong");
  a_done_hold: assert property (
    o_done && !(i_avs_write && i_avs_address == CPD_REG_CTRL) |=> o_done)
    else $error("done lost");
  a_done_idle: assert property (o_done |-> !o_fetch_req)
    else $error("fetch after done");
  c_load_done: cover property ($rose(o_done));
  c_last_byte: cover property (i_fetch_ack && o_fetch_addr == 16'h00F3);
  c_supplies: cover property (o_supplies_5v);
  c_analog: cover property (o_pad_used && o_pad_pull_enable_n);
endmodule
bind cpd_top cpd_checker u_chk (.i_ref_clk, .i_rst_b, .i_avs_address,
  .i_avs_read, .i_avs_write, .o_avs_readdata, .o_avs_waitrequest,
  .o_fetch_req, .o_fetch_addr, .i_fetch_ack, .o_done, .o_pad_word,
  .o_pad_used, .o_pad_slew, .o_pad_rx_enable, .o_pad_pull_direction_select,
  .o_pad_pull_enable_n, .o_pad_mux_mode, .o_supply_current, .o_supplies_5v);

// ### verif/cpd_eeprom_model.sv
`timescale 1ns/1ps
module cpd_eeprom_model (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_dirty,
  input wire logic i_fetch_req,
  input wire logic [15:0] i_fetch_addr,
  output logic o_fetch_ack,
  output logic [7:0] o_fetch_data
);
  // ----------------------------------------------------------------------
  // Record contents and byte server
  // ----------------------------------------------------------------------
  logic [1:0] wait_q;
  int acks;
  logic due;
  // Dirty mode sets reserved bits and a nonzero supplied current
  function automatic logic [7:0] byte_at(input logic [15:0] a);
    logic [7:0] b;
    b = {a[2:0], a[7:3]} ^ 8'h96;
    if (!i_dirty && a >= 16'h00F2) begin
      b = 8'h00;
    end else if (!i_dirty && a < 16'h00EC) begin
      b = a[0] ? b & 8'h7F : b & 8'h80;
    end
    return b;
  endfunction
  assign due = i_fetch_req && !o_fetch_ack && wait_q == i_fetch_addr[1:0];
  // Delay follows the address so answers come both promptly and slowly
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      wait_q <= 2'h0;
      acks <= 0;
      o_fetch_ack <= 1'b0;
      o_fetch_data <= 8'h00;
    end else if (due) begin
      o_fetch_ack <= 1'b1;
      o_fetch_data <= byte_at(i_fetch_addr);
      acks <= acks + 1;
      wait_q <= 2'h0;
    end else begin
      o_fetch_ack <= 1'b0;
      o_fetch_data <= ~o_fetch_data;
      wait_q <= (i_fetch_req && !o_fetch_ack) ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule

// ### verif/cape_pin_config_decoder_bench.sv
`timescale 1ns/1ps
module cape_pin_config_decoder_bench
  import cpd_pkg::*;
;
  logic i_ref_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [7:0] i_avs_address = 8'h00;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0000_0000;
  logic dirty = 1'b0;
  logic i_fetch_ack, o_avs_waitrequest, o_fetch_req, o_done, o_pad_used;
  logic o_pad_slew, o_pad_rx_enable, o_pad_pull_direction_select;
  logic o_pad_pull_enable_n, o_supplies_5v;
  logic [7:0] i_fetch_data;
  logic [2:0] o_pad_mux_mode;
  logic [31:0] o_avs_readdata;
  logic [15:0] o_fetch_addr, o_pad_word, o_rail_3v3_limit, o_rail_5v_limit;
  logic [15:0] o_system_5v_limit, o_supply_current;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  cpd_top uut (.i_ref_clk, .i_rst_b, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest,
    .o_fetch_req, .o_fetch_addr, .i_fetch_ack, .i_fetch_data, .o_done,
    .o_pad_word, .o_pad_used, .o_pad_slew, .o_pad_rx_enable,
    .o_pad_pull_direction_select, .o_pad_pull_enable_n, .o_pad_mux_mode,
    .o_rail_3v3_limit, .o_rail_5v_limit, .o_system_5v_limit,
    .o_supply_current, .o_supplies_5v);
  cpd_eeprom_model eep (.i_ref_clk, .i_rst_b, .i_dirty(dirty),
    .i_fetch_req(o_fetch_req), .i_fetch_addr(o_fetch_addr),
    .o_fetch_ack(i_fetch_ack), .o_fetch_data(i_fetch_data));
  // ----------------------------------------------------------------------
  // Bus tasks and checks
  // ----------------------------------------------------------------------
  always #50 i_ref_clk = ~i_ref_clk;
  // Loads take about seven hundred cycles; the ceiling leaves ample margin
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Request held until waitrequest is seen low; one idle edge follows
  task automatic av_rd(input logic [7:0] a, output logic [31:0] d);
    i_avs_address <= a;
    i_avs_read <= 1'b1;
    do @(posedge i_ref_clk); while (o_avs_waitrequest !== 1'b0);
    d = o_avs_readdata;
    i_avs_read <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  task automatic av_wr(input logic [7:0] a, input logic [31:0] d);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= 1'b1;
    do @(posedge i_ref_clk); while (o_avs_waitrequest !== 1'b0);
    i_avs_write <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] r;
    chk({o_avs_waitrequest, o_pad_pull_enable_n, o_done}, 3'b110);
    av_rd(CPD_REG_STATUS, r);
    chk(r, CPD_RESET_VALUE);
    av_rd(8'h20, r);
    chk(r, CPD_UNMAPPED);
    av_wr(8'h21, 32'h0000_0001);
    av_rd(CPD_REG_STATUS, r);
    chk(r, CPD_RESET_VALUE);
  endtask
  task automatic pin_sweep();
    logic [15:0] w;
    logic [7:0] f;
    logic [7:0] p;
    logic [31:0] r;
    for (int n = 0; n < CPD_PIN_WORDS; n++) begin
      av_wr(CPD_REG_STATUS, n);
      repeat (2) @(posedge i_ref_clk);
      w = {eep.byte_at(CPD_PIN_BASE + 16'(2 * n)),
        eep.byte_at(CPD_PIN_BASE + 16'(2 * n + 1))};
      f = (n >= CPD_FIRST_ANALOG) ? {w[15], 7'h08} : {w[15], w[6:0]};
      p = {o_pad_used, o_pad_slew, o_pad_rx_enable,
        o_pad_pull_direction_select, o_pad_pull_enable_n, o_pad_mux_mode};
      chk(o_pad_word, w);
      chk(p, f);
      av_rd(CPD_REG_PIN_BASE, r);
      chk(r, {16'h0000, w});
      av_rd(CPD_REG_CTRL, r);
      chk(r, n);
    end
  endtask
  task automatic t_load(input logic d);
    logic [31:0] r;
    logic [63:0] lims;
    logic [15:0] w;
    int a0;
    dirty <= d;
    a0 = eep.acks;
    av_wr(CPD_REG_CTRL, 32'h0000_0001);
    @(posedge i_ref_clk);
    chk(o_done, 1'b0);
    for (int i = 0; i < 5000 && o_done !== 1'b1; i++) @(posedge i_ref_clk);
    chk(o_done, 1'b1);
    chk(eep.acks - a0, 156);
    av_rd(CPD_REG_STATUS, r);
    chk(r, 32'h0000_0001);
    lims = {o_rail_3v3_limit, o_rail_5v_limit, o_system_5v_limit,
      o_supply_current};
    for (int k = 0; k < 4; k++) begin
      av_rd(CPD_REG_LIM_3V3 + 8'(k), r);
      w = {eep.byte_at(CPD_LIM_3V3_OFF + 16'(2 * k)),
        eep.byte_at(CPD_LIM_3V3_OFF + 16'(2 * k + 1))};
      chk(r, {16'h0000, w});
      chk(lims[63 - 16 * k -: 16], r);
    end
    chk(o_supplies_5v, d);
    pin_sweep();
  endtask
  initial begin
    repeat (3) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    @(posedge i_ref_clk);
    t_reset();
    t_load(1'b0);
    t_load(1'b1);
    tally_and_finish();
  end
endmodule
